// >>> billboard_trigger_regs.vh
// Register offsets, fields, reset values and timing counts of the billboard trigger control
`ifndef BILLBOARD_TRIGGER_REGS_VH
`define BILLBOARD_TRIGGER_REGS_VH

// ****************************************
// Register map
// ****************************************
`define BB_ADDR_W 4
`define BB_OFF_CONTROL 4'h0
`define BB_OFF_TIMER_LSB 4'h1
`define BB_OFF_TIMER_MSB 4'h2
`define BB_OFF_STATUS 4'h3

// ****************************************
// Control fields
// ****************************************
`define BB_CTL_ENABLE_BIT 0
`define BB_CTL_SEL_LSB 1
`define BB_CTL_SEL_MSB 5
`define BB_CTL_WMASK 8'h3F
`define BB_CTL_RESET 8'h14
`define BB_SEL_DEFAULT 5'h0A
`define BB_SEL_RESERVED 5'h09
`define BB_SEL_LAST 5'h10

// ****************************************
// Timing
// ****************************************
`define BB_TIMER_RESET 16'h07D0
`define BB_CLK_MHZ 250
`define BB_STEP_MS 10
`define BB_STEP_CYCLES (`BB_STEP_MS * 1000 * `BB_CLK_MHZ)

// ****************************************
// Sequencer states
// ****************************************
`define BB_ST_IDLE 3'h0
`define BB_ST_DETACH 3'h1
`define BB_ST_BILLBOARD 3'h2
`define BB_ST_TIMING 3'h3
`define BB_ST_DETACH_BACK 3'h4
`define BB_ST_DONE 3'h5

`endif

// >>> billboard_trigger_control.v
// Billboard trigger control: pin select, trigger sync, detach/reattach sequencing
//
// Functional notes
// - After failure signalled, let host enumerate the internal Billboard device.
// - Billboard descriptors carry failure message from prerecorded OTP contents.
// - Any general-purpose pin selectable as trigger, except pin 9 (its code 01001 is reserved); default pin when enabled.
// - Trigger input is active low; low level activates Billboard.
// - Control bits 5:1 select trigger pin; 01010 default, 01001 reserved.
// - Control bit 0 enables Billboard; when clear, trigger ignored entirely (the code checks it in idle only; a showing under way runs on).
// - On trigger, detach function device, then reconnect with Billboard descriptors.
// - Detach timer starts at address set, 10 ms steps, default 20 s.
`timescale 1ns/1ps
`default_nettype none
`include "billboard_trigger_regs.vh"

// ****************************************
// Limitations
// ****************************************
// Only the address-set detach timer is kept; the string-request timer is left out.
// Clearing the enable bit mid-sequence does not abort a showing already under way,
// so the function device is never left detached halfway through.

module billboard_trigger_control #(
   parameter NUM_PINS = 17,
   parameter STEP_CYCLES = `BB_STEP_CYCLES
) (
   input wire ref_clk_i, // Core clock, 250 MHz
   input wire rst_i, // Synchronous reset, active high
   input wire clk_en_i, // Clock enable, freezes all state when low
   input wire [`BB_ADDR_W-1:0] addr_i, // Register address
   input wire [7:0] wdata_i, // Register write data
   input wire wr_i, // Write strobe
   input wire rd_i, // Read strobe
   output reg [7:0] rdata_o, // Read data, valid cycle after read strobe
   input wire [NUM_PINS-1:0] gpio_n_i, // General-purpose pins, indexed by select code
   input wire addr_assigned_i, // Pulse: host set the function device address
   input wire detach_done_i, // Pulse: function device detach has completed
   output reg detach_req_o, // Hold function device disconnected from its port
   output reg billboard_mode_o, // Present Billboard descriptors when attached
   output reg otp_msg_sel_o // Descriptor engine takes the failure text from OTP
);

   // ****************************************
   // Registers
   // ****************************************
   reg [7:0] control_reg;
   reg [15:0] timer_reload_reg;

   reg [2:0] state_reg;
   reg [2:0] sync_reg;
   reg trig_reg;

   reg [15:0] step_count_reg;
   reg [31:0] cycle_count_reg;

   // ****************************************
   // Sequencer state codes
   // ****************************************
   localparam [2:0] ST_IDLE = `BB_ST_IDLE;
   localparam [2:0] ST_DETACH = `BB_ST_DETACH;
   localparam [2:0] ST_BILLBOARD = `BB_ST_BILLBOARD;
   localparam [2:0] ST_TIMING = `BB_ST_TIMING;
   localparam [2:0] ST_DETACH_BACK = `BB_ST_DETACH_BACK;
   localparam [2:0] ST_DONE = `BB_ST_DONE;

   wire [4:0] pin_sel = control_reg[`BB_CTL_SEL_MSB:`BB_CTL_SEL_LSB];
   wire enabled = control_reg[`BB_CTL_ENABLE_BIT];

   // ****************************************
   // Pin select table
   // ****************************************
   // Reserved and out-of-table codes match no entry and read as inactive (high)
   wire [NUM_PINS-1:0] pin_hit;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
         assign pin_hit[gi] = (pin_sel == gi) && (gi != `BB_SEL_RESERVED) && !gpio_n_i[gi];
      end
   endgenerate
   wire raw_pin = ~|pin_hit;

   // One tick per timer step; the counter restarts on every tick
   wire step_tick = (cycle_count_reg == STEP_CYCLES - 1);
   wire timer_expired = step_tick && (step_count_reg + 16'h0001 >= timer_reload_reg);

   // ****************************************
   // Register bus
   // ****************************************
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         control_reg <= `BB_CTL_RESET;
         timer_reload_reg <= `BB_TIMER_RESET;
         rdata_o <= 8'h00;
      end else if (clk_en_i) begin
         if (wr_i) begin
            if (addr_i == `BB_OFF_CONTROL) begin
               control_reg <= wdata_i & `BB_CTL_WMASK;
            end else if (addr_i == `BB_OFF_TIMER_LSB) begin
               timer_reload_reg[7:0] <= wdata_i;
            end else if (addr_i == `BB_OFF_TIMER_MSB) begin
               timer_reload_reg[15:8] <= wdata_i;
            end
         end

         // Read data stand one cycle only, zero otherwise
         rdata_o <= 8'h00;
         if (rd_i) begin
            if (addr_i == `BB_OFF_CONTROL) begin
               rdata_o <= control_reg;
            end else if (addr_i == `BB_OFF_TIMER_LSB) begin
               rdata_o <= timer_reload_reg[7:0];
            end else if (addr_i == `BB_OFF_TIMER_MSB) begin
               rdata_o <= timer_reload_reg[15:8];
            end else if (addr_i == `BB_OFF_STATUS) begin
               rdata_o <= {3'h0, trig_reg, 1'b0, state_reg};
            end
         end
      end
   end

   // ****************************************
   // Trigger synchroniser
   // ****************************************
   // Three stages; a level change counts once stages two and three agree
   // Stages reset to the idle (high) pin level so no false trigger follows reset
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         sync_reg <= 3'h7;
         trig_reg <= 1'b0;
      end else if (clk_en_i) begin
         sync_reg <= {sync_reg[1:0], raw_pin};
         if (sync_reg[1] == sync_reg[2]) begin
            trig_reg <= ~sync_reg[2];
         end
      end
   end

   // ****************************************
   // Detach / Billboard sequencer
   // ****************************************
   // No negotiation lives here: the low pin level is the only failure input
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_reg <= `BB_ST_IDLE;
         step_count_reg <= 16'h0000;
         cycle_count_reg <= 32'h0000_0000;
         detach_req_o <= 1'b0;
         billboard_mode_o <= 1'b0;
         otp_msg_sel_o <= 1'b0;
      end else if (clk_en_i) begin
         case (state_reg)
            // Waiting for a synchronised low trigger while enabled
            ST_IDLE: begin
               if (enabled && trig_reg) begin
                  detach_req_o <= 1'b1;
                  state_reg <= ST_DETACH;
               end
            end

            // Function device held off its port until the detach completes
            ST_DETACH: begin
               if (detach_done_i) begin
                  detach_req_o <= 1'b0;
                  billboard_mode_o <= 1'b1;
                  otp_msg_sel_o <= 1'b1;
                  state_reg <= ST_BILLBOARD;
               end
            end

            // Attached as Billboard, timer armed by the host's address assignment
            ST_BILLBOARD: begin
               if (addr_assigned_i) begin
                  step_count_reg <= 16'h0000;
                  cycle_count_reg <= 32'h0000_0000;
                  state_reg <= ST_TIMING;
               end
            end

            // A reload of zero still waits one full step
            ST_TIMING: begin
               if (step_tick) begin
                  cycle_count_reg <= 32'h0000_0000;
                  step_count_reg <= step_count_reg + 16'h0001;
               end else begin
                  cycle_count_reg <= cycle_count_reg + 32'h0000_0001;
               end
               if (timer_expired) begin
                  detach_req_o <= 1'b1;
                  state_reg <= ST_DETACH_BACK;
               end
            end

            // Second detach, then reattach with standard descriptors
            ST_DETACH_BACK: begin
               if (detach_done_i) begin
                  detach_req_o <= 1'b0;
                  billboard_mode_o <= 1'b0;
                  otp_msg_sel_o <= 1'b0;
                  state_reg <= ST_DONE;
               end
            end

            ST_DONE: begin
               // One Billboard showing per failure; rearm once the pin returns high
               if (!trig_reg) begin
                  state_reg <= ST_IDLE;
               end
            end

            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // billboard_trigger_control
`default_nettype wire

// >>> bb_checker.sv
// Assertion checker for the billboard trigger control
`timescale 1ns/1ps
`default_nettype none
`include "billboard_trigger_regs.vh"
module bb_checker #(parameter NUM_PINS = 17, parameter STEP_CYCLES = 4) (
   input wire logic ref_clk_i, // Clk
   input wire logic rst_i, // Rst
   input wire logic clk_en_i, // Run
   input wire logic [3:0] addr_i, // Adr
   input wire logic [7:0] wdata_i, // Wd
   input wire logic wr_i, // Wr
   input wire logic rd_i, // Rd
   input wire logic [7:0] rdata_o, // Rdata
   input wire logic [NUM_PINS-1:0] gpio_n_i, // Pins
   input wire logic addr_assigned_i, // Adr set
   input wire logic detach_done_i, // Gone
   input wire logic detach_req_o, // Detach
   input wire logic billboard_mode_o, // Mode
   input wire logic otp_msg_sel_o // Otp
);
   logic [7:0] ctl;
   logic [15:0] tmr;
   logic [31:0] cnt;
   logic run;
   wire pin = gpio_n_i[ctl[5:1]];
   // Reload of zero still waits one step
   wire [31:0] lim = (tmr == 0 ? 32'd1 : {16'd0, tmr}) * STEP_CYCLES;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ctl <= `BB_CTL_RESET;
         tmr <= `BB_TIMER_RESET;
         run <= 1'b0;
      end else if (clk_en_i) begin
         if (wr_i && addr_i == `BB_OFF_CONTROL) ctl <= wdata_i & `BB_CTL_WMASK;
         if (wr_i && addr_i == `BB_OFF_TIMER_LSB) tmr[7:0] <= wdata_i;
         if (wr_i && addr_i == `BB_OFF_TIMER_MSB) tmr[15:8] <= wdata_i;
         run <= billboard_mode_o && (run || addr_assigned_i);
         cnt <= run ? cnt + 1 : 32'd1;
      end
   end
   default clocking dc @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_go; $rose(detach_req_o) && !billboard_mode_o; endsequence
   property p_otp; otp_msg_sel_o == billboard_mode_o; endproperty
   a_otp: assert property (p_otp) else $error("otp select off");
   property p_rd; clk_en_i && rd_i && addr_i == 0 |=> rdata_o == ctl; endproperty
   a_rd: assert property (p_rd) else $error("control readback");
   property p_en; s_go |-> $past(ctl[0]); endproperty
   a_en: assert property (p_en) else $error("disabled trigger");
   property p_sync; s_go |-> !$past(pin, 2) && !$past(pin, 3); endproperty
   a_sync: assert property (p_sync) else $error("pin not low");
   property p_bb; $rose(billboard_mode_o) |-> $past(detach_done_i) && !detach_req_o; endproperty
   a_bb: assert property (p_bb) else $error("early billboard");
   property p_back; clk_en_i && billboard_mode_o && detach_req_o && detach_done_i
      |=> !billboard_mode_o && !detach_req_o; endproperty
   a_back: assert property (p_back) else $error("no reattach");
   property p_tmr; $rose(detach_req_o) && billboard_mode_o |-> run && cnt >= lim && cnt <= lim + 3;
   endproperty
   a_tmr: assert property (p_tmr) else $error("timer early");
   property p_tmax; run && billboard_mode_o && !detach_req_o |-> cnt <= lim + 3; endproperty
   a_tmax: assert property (p_tmax) else $error("timer late");
   c_bb: cover property ($rose(billboard_mode_o));
   c_back: cover property ($fell(billboard_mode_o));
   c_go: cover property (s_go);
endmodule // bb_checker
bind billboard_trigger_control bb_checker #(.NUM_PINS(NUM_PINS), .STEP_CYCLES(STEP_CYCLES)) chk (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .gpio_n_i(gpio_n_i),
   .addr_assigned_i(addr_assigned_i), .detach_done_i(detach_done_i),
   .detach_req_o(detach_req_o), .billboard_mode_o(billboard_mode_o), .otp_msg_sel_o(otp_msg_sel_o));
`default_nettype wire

// >>> pd_model.sv
// Power delivery controller model driving the trigger pins
`timescale 1ns/1ps
`default_nettype none
module pd_model #(parameter NUM_PINS = 17) (
   input wire logic fail_i, // Negotiation failed
   input wire logic [4:0] sel_i, // Wired pin
   output logic [NUM_PINS-1:0] gpio_n_o // Pulled up
);
   // Negotiation stays here; the hub only sees the pin
   always_comb begin
      gpio_n_o = '1;
      if (fail_i && sel_i < NUM_PINS) gpio_n_o[sel_i] = 1'b0;
   end
endmodule // pd_model
`default_nettype wire

// >>> billboard_trigger_control_test.sv
// Bench for the billboard trigger control
`timescale 1ns/1ps
`default_nettype none
`include "billboard_trigger_regs.vh"
module billboard_trigger_control_test;
   logic ref_clk_i = 0, rst_i = 1, wr = 0, rd = 0, fail = 0, done = 0, asg = 0, en = 1;
   logic [3:0] a = 0;
   logic [7:0] wd = 0, q;
   logic [4:0] sel = 0;
   logic [16:0] pins;
   logic det, bb, otp;
   int n_errors = 0, checked = 0, n, r;
   always #2 ref_clk_i = ~ref_clk_i;
   pd_model pd (.fail_i(fail), .sel_i(sel), .gpio_n_o(pins));
   billboard_trigger_control #(.NUM_PINS(17), .STEP_CYCLES(4)) dut (.ref_clk_i(ref_clk_i),
      .rst_i(rst_i), .clk_en_i(en), .addr_i(a), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(q),
      .gpio_n_i(pins), .addr_assigned_i(asg), .detach_done_i(done), .detach_req_o(det),
      .billboard_mode_o(bb), .otp_msg_sel_o(otp));
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value at %0t: %h expected %h", $time, s, e);
      end
   endtask
   task end_of_test;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task bus(input logic w, input logic [3:0] ad, input logic [7:0] d);
      @(posedge ref_clk_i);
      wr <= w; rd <= !w; a <= ad; wd <= d;
      @(posedge ref_clk_i);
      wr <= 0; rd <= 0;
      #1;
   endtask
   task wt(input int bound);
      for (n = 0; det !== 1'b1 && n < bound; n++) begin
         @(posedge ref_clk_i);
         #1;
      end
   endtask
   task pulse(input logic which);
      @(posedge ref_clk_i);
      done <= which; asg <= !which;
      @(posedge ref_clk_i);
      done <= 0; asg <= 0;
      #1;
   endtask
   initial begin
      void'($urandom(76));
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 0;
      bus(0, `BB_OFF_CONTROL, 0); chk(q, `BB_CTL_RESET);
      // A write while the clock enable is low must leave the control register alone
      @(posedge ref_clk_i);
      en <= 0;
      bus(1, `BB_OFF_CONTROL, 8'h3F);
      @(posedge ref_clk_i);
      en <= 1;
      bus(0, `BB_OFF_CONTROL, 0); chk(q, `BB_CTL_RESET);
      repeat (4) begin
         r = $urandom;
         bus(1, `BB_OFF_CONTROL, r[7:0]);
         bus(0, `BB_OFF_CONTROL, 0); chk(q, r[7:0] & `BB_CTL_WMASK);
      end
      bus(1, `BB_OFF_CONTROL, {2'b0, `BB_SEL_DEFAULT, 1'b0});
      sel <= `BB_SEL_DEFAULT; fail <= 1;
      wt(30); chk(det, 0);
      fail <= 0;
      for (int c = 0; c <= `BB_SEL_LAST; c++) begin
         repeat (8) @(posedge ref_clk_i);
         r = $urandom_range(3);
         bus(1, `BB_OFF_TIMER_LSB, r[7:0]);
         bus(1, `BB_OFF_TIMER_MSB, 0);
         bus(1, `BB_OFF_CONTROL, {2'b0, c[4:0], 1'b1});
         sel <= c[4:0]; fail <= 1;
         wt(40); chk(det, c != `BB_SEL_RESERVED);
         if (det === 1'b1) begin
            chk(bb, 0);
            pulse(1); chk({det, bb, otp}, 3'b011);
            pulse(0); wt(300);
            r = (r == 0 ? 1 : r) * 4;
            chk(n >= r && n <= r + 3, 1);
            if (det !== 1'b1) end_of_test;
            pulse(1); chk({det, bb, otp}, 0);
         end else if (c != `BB_SEL_RESERVED) end_of_test;
         fail <= 0;
      end
      end_of_test;
   end
endmodule // billboard_trigger_control_test
`default_nettype wire
